// *** logic/ais_pkg.sv ***
// ais_pkg: constants and types shared by the converter's two-wire slave interface
// assumes a single 25 MHz system clock; pins are sampled, never used as clocks
package ais_pkg;

  // system clock and conversion timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TYP_NS = 1300;
  localparam int CONV_MAX_NS = 1800;
  // longest time rounds down to whole cycles
  localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

  // supported bus rates; fast mode half period still spans many clk cycles
  localparam int STD_KBPS = 100;
  localparam int FAST_KBPS = 400;
  localparam int FAST_HALF_CYC = (1000000 / FAST_KBPS) / (2 * CLK_PERIOD_NS);

  // register widths and reset values
  localparam int RESULT_W = 12;
  localparam int CFG_W = 6;
  localparam int TRAIL_ZEROS = 4;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // configuration word field positions, first received bit is the top one
  localparam int CFG_SD_BIT = 5;
  localparam int CFG_OS_BIT = 4;
  localparam int CFG_SEL_HI_BIT = 3;
  localparam int CFG_SEL_LO_BIT = 2;
  localparam int CFG_UNI_BIT = 1;
  localparam int CFG_SLP_BIT = 0;

  // three-level strap encoding
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // slave addresses, indexed by strap b then strap a
  localparam logic [6:0] ADDR_LL = 7'h08;
  localparam logic [6:0] ADDR_LF = 7'h09;
  localparam logic [6:0] ADDR_LH = 7'h0A;
  localparam logic [6:0] ADDR_FH = 7'h0B;
  localparam logic [6:0] ADDR_FF = 7'h18;
  localparam logic [6:0] ADDR_FL = 7'h19;
  localparam logic [6:0] ADDR_HL = 7'h1A;
  localparam logic [6:0] ADDR_HF = 7'h1B;
  localparam logic [6:0] ADDR_HH = 7'h28;
  localparam logic [6:0] ADDR_NONE = 7'h00;

  // direction bit value for a read
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_RD_DATA = 3'h3,
    ST_RD_ACK = 3'h4,
    ST_WR_DATA = 3'h5,
    ST_WR_ACK = 3'h6
  } ais_state_e;

endpackage

// *** logic/ais_conv_timer.sv ***
// ais_conv_timer: conversion sequencer timed from the internal clock
// assumes start is a one-cycle pulse from the bus logic on the same clock
`timescale 1ns/100ps
module ais_conv_timer #(
  parameter int CYC = ais_pkg::CONV_CYC,
  parameter int W = ais_pkg::RESULT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [W-1:0] sample_data,
  output logic busy,
  output logic [W-1:0] result
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
    logic [W-1:0] result;
  } ais_timer_s;

  ais_timer_s q;
  ais_timer_s d;

  // busy spans exactly CYC cycles, result latched as it drops
  always_comb begin
    d = q;
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.cnt = LOAD;
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.result = sample_data;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign result = q.result;

  AST_CONV_LEN: assert property (@(posedge clk) disable iff (!nrst)
    start && !busy |=> busy ##44 busy ##1 !busy)
    else $error("conversion length wrong");

  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !busy && !$past(busy) |-> $stable(result))
    else $error("result changed outside conversion end");

  COV_CONV: cover property (@(posedge clk) disable iff (!nrst) $fell(busy));

endmodule

// *** logic/ais_i2c_slave.sv ***
// ais_i2c_slave: two-wire slave interface of an 8-channel 12-bit converter
// assumes scl, sda and straps are asynchronous pins; sda wire resolved outside
// Operation
// - conversion timed by internal clock, at most 1.8 us
// - data line only pulled low or released, never driven high
// - works at 100 kbit/s and 400 kbit/s bus rates
// - slave only; serial clock is input, data line bidirectional
// - detect Start and Stop; busy after Start, free after Stop
// - Repeated Start behaves like Start, bus stays busy
// - transfers are eight data bits plus one acknowledge bit
// - ack pulls line low; nak leaves it released
// - data line changes only while serial clock low
// - 7-bit address then direction bit; 1 read, 0 write
// - selected only when address equals strap-chosen address
// - nak while converting, ack once conversion finished
// - latest 12-bit result held and returned on read
// - 6-bit configuration register loaded by writes
// - Stop after successful addressing starts a conversion
// - read sends 12 result bits msb first, then 4 zeros
// - configuration bits captured on rising edges, single_diff bit first
// - address from two three-level straps, nine values
`timescale 1ns/100ps
module ais_i2c_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  input wire logic [ais_pkg::RESULT_W-1:0] sample_data,
  output logic conv_start,
  output logic conv_busy,
  output logic bus_busy,
  output logic single_diff,
  output logic odd_sign,
  output logic channel_sel_hi,
  output logic channel_sel_lo,
  output logic unipolar_select,
  output logic sleep_select
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [3:0] strap_m;
    logic [3:0] strap_s;
    ais_pkg::ais_state_e st;
    logic [3:0] cnt;
    logic [7:0] rx;
    logic [15:0] tx;
    logic rw;
    logic armed;
    logic byte2;
    logic oe;
    logic sda_lo;
    logic [ais_pkg::CFG_W-1:0] cfg;
    logic conv_start;
    logic bus_busy;
  } ais_main_s;

  ais_main_s q;
  ais_main_s d;
  logic busy;
  logic [ais_pkg::RESULT_W-1:0] result;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic [6:0] own_addr;

  // strap pair to slave address
  function automatic logic [6:0] strap_addr(input logic [1:0] b, input logic [1:0] a);
    logic [6:0] r;
    r = ais_pkg::ADDR_NONE;
    case ({b, a})
      {ais_pkg::STRAP_LOW, ais_pkg::STRAP_LOW}: r = ais_pkg::ADDR_LL;
      {ais_pkg::STRAP_LOW, ais_pkg::STRAP_FLOAT}: r = ais_pkg::ADDR_LF;
      {ais_pkg::STRAP_LOW, ais_pkg::STRAP_HIGH}: r = ais_pkg::ADDR_LH;
      {ais_pkg::STRAP_FLOAT, ais_pkg::STRAP_HIGH}: r = ais_pkg::ADDR_FH;
      {ais_pkg::STRAP_FLOAT, ais_pkg::STRAP_FLOAT}: r = ais_pkg::ADDR_FF;
      {ais_pkg::STRAP_FLOAT, ais_pkg::STRAP_LOW}: r = ais_pkg::ADDR_FL;
      {ais_pkg::STRAP_HIGH, ais_pkg::STRAP_LOW}: r = ais_pkg::ADDR_HL;
      {ais_pkg::STRAP_HIGH, ais_pkg::STRAP_FLOAT}: r = ais_pkg::ADDR_HF;
      {ais_pkg::STRAP_HIGH, ais_pkg::STRAP_HIGH}: r = ais_pkg::ADDR_HH;
      default: r = ais_pkg::ADDR_NONE;
    endcase
    return r;
  endfunction

  // conversion sequencer
  ais_conv_timer #(
    .CYC(ais_pkg::CONV_CYC),
    .W(ais_pkg::RESULT_W)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(q.conv_start),
    .sample_data(sample_data),
    .busy(busy),
    .result(result)
  );

  // bus events seen on the synchronised copies only
  assign scl_rise = q.scl_s && !q.scl_p;
  assign scl_fall = !q.scl_s && q.scl_p;
  assign start_evt = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
  assign stop_evt = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
  assign own_addr = strap_addr(q.strap_s[3:2], q.strap_s[1:0]);

  // next state of the whole slave
  always_comb begin
    d = q;
    d.conv_start = 1'b0;
    d.sda_lo = 1'b0;
    d.scl_m = scl_in;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_in;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.strap_m = {addr_strap_b, addr_strap_a};
    d.strap_s = q.strap_m;
    if (start_evt) begin
      d.st = ais_pkg::ST_ADDR;
      d.cnt = '0;
      d.oe = 1'b0;
      d.bus_busy = 1'b1;
    end else if (stop_evt) begin
      d.st = ais_pkg::ST_IDLE;
      d.oe = 1'b0;
      d.bus_busy = 1'b0;
      if (q.armed) begin
        d.conv_start = 1'b1;
        d.armed = 1'b0;
      end
    end else begin
      unique case (q.st)
        ais_pkg::ST_IDLE: begin
          d.oe = 1'b0;
        end
        ais_pkg::ST_ADDR: begin
          if (scl_rise) begin
            d.rx = {q.rx[6:0], q.sda_s};
            d.cnt = 4'(q.cnt + 4'h1);
          end
          if (scl_fall && q.cnt == ais_pkg::BYTE_DONE) begin
            if (q.rx[7:1] == own_addr && !busy) begin
              d.oe = 1'b1;
              d.st = ais_pkg::ST_ADDR_ACK;
              d.rw = q.rx[0];
              d.armed = 1'b1;
            end else begin
              d.st = ais_pkg::ST_IDLE;
            end
          end
        end
        ais_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.cnt = '0;
            if (q.rw == ais_pkg::DIR_READ) begin
              d.st = ais_pkg::ST_RD_DATA;
              d.tx = {result, ais_pkg::TRAIL_ZEROS'(0)};
              d.oe = !result[ais_pkg::RESULT_W-1];
              d.byte2 = 1'b0;
            end else begin
              d.st = ais_pkg::ST_WR_DATA;
              d.oe = 1'b0;
            end
          end
        end
        ais_pkg::ST_RD_DATA: begin
          if (scl_rise) begin
            d.cnt = 4'(q.cnt + 4'h1);
          end
          if (scl_fall) begin
            if (q.cnt == ais_pkg::BYTE_DONE) begin
              d.oe = 1'b0;
              d.st = ais_pkg::ST_RD_ACK;
            end else begin
              d.tx = {q.tx[14:0], 1'b0};
              d.oe = !q.tx[14];
            end
          end
        end
        ais_pkg::ST_RD_ACK: begin
          if (scl_rise && (q.sda_s || q.byte2)) begin
            d.st = ais_pkg::ST_IDLE;
          end else if (scl_fall) begin
            d.tx = {q.tx[14:0], 1'b0};
            d.oe = !q.tx[14];
            d.byte2 = 1'b1;
            d.cnt = '0;
            d.st = ais_pkg::ST_RD_DATA;
          end
        end
        ais_pkg::ST_WR_DATA: begin
          if (scl_rise) begin
            d.rx = {q.rx[6:0], q.sda_s};
            d.cnt = 4'(q.cnt + 4'h1);
          end
          if (scl_fall && q.cnt == ais_pkg::BYTE_DONE) begin
            d.cfg = q.rx[7:2];
            d.oe = 1'b1;
            d.st = ais_pkg::ST_WR_ACK;
          end
        end
        ais_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            d.oe = 1'b0;
            d.st = ais_pkg::ST_IDLE;
          end
        end
        default: begin
          d.st = ais_pkg::ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.cfg <= ais_pkg::CFG_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign sda_out = q.sda_lo;
  assign sda_oe = q.oe;
  assign conv_start = q.conv_start;
  assign conv_busy = busy;
  assign bus_busy = q.bus_busy;
  assign single_diff = q.cfg[ais_pkg::CFG_SD_BIT];
  assign odd_sign = q.cfg[ais_pkg::CFG_OS_BIT];
  assign channel_sel_hi = q.cfg[ais_pkg::CFG_SEL_HI_BIT];
  assign channel_sel_lo = q.cfg[ais_pkg::CFG_SEL_LO_BIT];
  assign unipolar_select = q.cfg[ais_pkg::CFG_UNI_BIT];
  assign sleep_select = q.cfg[ais_pkg::CFG_SLP_BIT];

  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!nrst)
    sda_out == 1'b0)
    else $error("data line driven high");

  AST_START: assert property (@(posedge clk) disable iff (!nrst)
    start_evt |=> q.st == ais_pkg::ST_ADDR && q.cnt == 4'h0 && bus_busy && !sda_oe)
    else $error("start not taken");

  AST_ACK: assert property (@(posedge clk) disable iff (!nrst)
    q.st == ais_pkg::ST_ADDR && !start_evt && !stop_evt && scl_fall
    && q.cnt == 4'h8 && q.rx[7:1] == own_addr && !busy |=> sda_oe ##1 sda_oe)
    else $error("no ack on own address");

  AST_NAK_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    q.st == ais_pkg::ST_ADDR && scl_fall && q.cnt == 4'h8 && busy
    |=> !sda_oe && q.st == ais_pkg::ST_IDLE)
    else $error("ack given while converting");

  AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (!nrst)
    q.st == ais_pkg::ST_ADDR && scl_fall && q.cnt == 4'h8 && q.rx[7:1] != own_addr
    |=> !sda_oe)
    else $error("ack on foreign address");

  AST_STOP_CONV: assert property (@(posedge clk) disable iff (!nrst)
    stop_evt && q.armed |=> conv_start ##1 (!conv_start && conv_busy))
    else $error("stop did not start conversion");

  AST_SCL_LOW: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sda_oe) |-> !q.scl_s)
    else $error("data changed with clock high");

  AST_WRITE_CFG: assert property (@(posedge clk) disable iff (!nrst)
    q.st == ais_pkg::ST_WR_DATA && !start_evt && !stop_evt && scl_fall && q.cnt == 4'h8
    |=> q.cfg == $past(q.rx[7:2]))
    else $error("configuration not captured");

  AST_READ_MSB: assert property (@(posedge clk) disable iff (!nrst)
    q.st == ais_pkg::ST_ADDR_ACK && !start_evt && !stop_evt && scl_fall && q.rw
    |=> sda_oe == !result[11] && q.tx[3:0] == 4'h0)
    else $error("first result bit wrong");

  COV_READ: cover property (@(posedge clk) q.st == ais_pkg::ST_RD_DATA && q.byte2);
  COV_WRITE: cover property (@(posedge clk) q.st == ais_pkg::ST_WR_ACK);
  COV_NAK: cover property (@(posedge clk) q.st == ais_pkg::ST_ADDR && scl_fall && busy);
  COV_CONV: cover property (@(posedge clk) conv_start);

endmodule

// *** testbench/ais_bus_master.sv ***
// ais_bus_master: behavioural two-wire bus master for the slave bench
// assumes a pull-up outside resolves sda; scl idles high between frames
`timescale 1ns/100ps
module ais_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // wait n system clocks, then move just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bit: data moves only while scl is low, sampled in the high phase
  task automatic bit_io(input logic v, output logic s);
    scl = 1'b0;
    step(2);
    sda_pull = ~v;
    step(2);
    scl = 1'b1;
    step(2);
    s = sda;
    step(2);
  endtask

  // start, or repeated start when rep is set: sda falls while scl high
  task automatic start_cond(input logic rep);
    if (rep) begin
      scl = 1'b0;
      step(2);
      sda_pull = 1'b0;
      step(2);
      scl = 1'b1;
      step(2);
    end
    sda_pull = 1'b1;
    step(4);
  endtask

  // stop: sda rises while scl high
  task automatic stop_cond();
    scl = 1'b0;
    step(2);
    sda_pull = 1'b1;
    step(2);
    scl = 1'b1;
    step(2);
    sda_pull = 1'b0;
    step(6);
  endtask

  // eight bits msb first, then release for the slave's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // eight bits from the slave, then our own ack or nak
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack_it, s);
  endtask
endmodule

// *** testbench/test_adc_i2c_slave.sv ***
// test_adc_i2c_slave: self-checking bench for the two-wire slave interface
// assumes ais_bus_master drives scl and pulls sda; pull-up modelled here
`timescale 1ns/100ps
module test_adc_i2c_slave;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic sda_pull;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic [1:0] strap_a = 2'h0;
  logic [1:0] strap_b = 2'h0;
  logic [11:0] sample = 12'h000;
  logic conv_start;
  logic conv_busy;
  logic bus_busy;
  logic [5:0] cfg;
  logic cfg_sd;
  logic cfg_os;
  logic cfg_hi;
  logic cfg_lo;
  logic cfg_uni;
  logic cfg_slp;
  logic [31:0] seed = 32'ha6ba_0a99;
  int errors = 0;
  int comparisons = 0;
  int starts = 0;
  int run_len = 0;
  int last_len = 0;

  // clock and open-drain wire with pull-up
  always #20 clk = ~clk;
  assign sda_wire = ~((sda_oe & ~sda_out) | sda_pull);
  // configuration outputs gathered in received order
  assign cfg = {cfg_sd, cfg_os, cfg_hi, cfg_lo, cfg_uni, cfg_slp};

  ais_i2c_slave i_dut (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_a(strap_a), .addr_strap_b(strap_b),
    .sample_data(sample), .conv_start(conv_start), .conv_busy(conv_busy),
    .bus_busy(bus_busy), .single_diff(cfg_sd), .odd_sign(cfg_os),
    .channel_sel_hi(cfg_hi), .channel_sel_lo(cfg_lo), .unipolar_select(cfg_uni),
    .sleep_select(cfg_slp)
  );

  ais_bus_master i_master (.clk(clk), .sda(sda_wire), .scl(scl), .sda_pull(sda_pull));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // slave address for strap b, strap a
  function automatic logic [6:0] addr_of(input logic [1:0] b, input logic [1:0] a);
    case ({b, a})
      4'h0: return 7'h08;
      4'h1: return 7'h09;
      4'h2: return 7'h0a;
      4'h6: return 7'h0b;
      4'h5: return 7'h18;
      4'h4: return 7'h19;
      4'h8: return 7'h1a;
      4'h9: return 7'h1b;
      4'ha: return 7'h28;
      default: return 7'h00;
    endcase
  endfunction

  // count conversions, length of each busy stretch, drive value of sda
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts++;
    end
    if (conv_busy === 1'b1) begin
      run_len++;
    end else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
    if (sda_oe === 1'b1) begin
      check("sda_out", sda_out, 16'h0000);
    end
  end

  // one frame up to the stop: address, then a write byte or two read bytes
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic rep,
                      input logic [7:0] wdata, output logic ack, output logic [15:0] rdata);
    logic a2;
    rdata = 16'h0000;
    i_master.start_cond(rep);
    i_master.send_byte({addr, rd}, ack);
    check("bus_busy", bus_busy, 16'h0001);
    if (ack && !rd) begin
      i_master.send_byte(wdata, a2);
      check("data ack", a2, 16'h0001);
    end else if (ack) begin
      i_master.recv_byte(1'b1, rdata[15:8]);
      i_master.recv_byte(1'b0, rdata[7:0]);
    end
  endtask

  task automatic stop_tb();
    i_master.stop_cond();
    check("bus_busy", bus_busy, 16'h0000);
  endtask

  // wait out a conversion, then check count and length
  task automatic wait_conv(input int exp_starts);
    int n;
    n = 0;
    i_master.step(4);
    while (conv_busy !== 1'b0 && n < 200) begin
      i_master.step(1);
      n++;
    end
    i_master.step(1);
    check("conv end", 16'(n < 200), 16'h0001);
    check("conv count", 16'(starts), 16'(exp_starts));
    check("busy length", 16'(last_len), 16'(ais_pkg::CONV_CYC));
  endtask

  initial begin
    #1000000;
    errors++;
    tally_and_finish();
  end

  initial begin
    logic ack;
    logic [15:0] rd;
    logic [7:0] wcfg;
    logic [11:0] exp_res;
    logic [6:0] addr;
    int nconv;
    nconv = 0;
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    i_master.step(6);
    check("reset state", {bus_busy, conv_busy, cfg}, 16'h0000);
    for (int k = 0; k < 9; k++) begin
      strap_b = 2'(k / 3);
      strap_a = 2'(k % 3);
      addr = addr_of(strap_b, strap_a);
      i_master.step(8);
      seed = next_rand(seed);
      wcfg = seed[7:0];
      sample = seed[19:8];
      xfer(addr, 1'b0, 1'b0, wcfg, ack, rd);
      check("write ack", ack, 16'h0001);
      check("config", cfg, wcfg[7:2]);
      stop_tb();
      nconv++;
      wait_conv(nconv);
      exp_res = sample;
      // an address outside the strap table is ignored, no conversion
      xfer(addr ^ 7'h40, 1'b1, 1'b0, 8'h00, ack, rd);
      check("foreign ack", ack, 16'h0000);
      stop_tb();
      i_master.step(10);
      check("no conversion", 16'(starts), 16'(nconv));
      xfer(addr, 1'b1, 1'b0, 8'h00, ack, rd);
      check("read ack", ack, 16'h0001);
      check("read data", rd, {exp_res, 4'h0});
      // write and read behind repeated starts, one conversion at the stop
      seed = next_rand(seed);
      wcfg = seed[7:0];
      xfer(addr, 1'b0, 1'b1, wcfg, ack, rd);
      check("rs write ack", ack, 16'h0001);
      xfer(addr, 1'b1, 1'b1, 8'h00, ack, rd);
      check("rs read data", rd, {exp_res, 4'h0});
      sample = seed[27:16];
      stop_tb();
      nconv++;
      wait_conv(nconv);
      check("config", cfg, wcfg[7:2]);
    end
    // illegal strap level selects no address
    strap_a = 2'h3;
    i_master.step(8);
    xfer(7'h28, 1'b0, 1'b0, 8'h00, ack, rd);
    check("strap none ack", ack, 16'h0000);
    stop_tb();
    i_master.step(10);
    check("no conversion", 16'(starts), 16'(nconv));
    tally_and_finish();
  end
endmodule
